// ===== rtl/mviu_pkg.sv
// Purpose: Shared constants and carrier types of the vectored interrupt unit.
// Assumes: APB register word per offset, 13-bit program counter.
// Notes: Source index 0 has the highest priority.
package mviu_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 4;
	localparam int NSRC = 5;
	localparam int NEP = 4;

	// ----------------------------------------------------------------
	// Register offsets and reset value
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_EP_REQ = 8'h08;
	localparam logic [7:0] OFS_BUS_CS = 8'h0c;
	localparam logic [7:0] OFS_TMR0_CTRL = 8'h10;
	localparam logic [7:0] OFS_TMR1_CTRL = 8'h14;
	localparam logic [7:0] OFS_STACK = 8'h18;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int B_GIE = 0;
	localparam int B_USB_EN = 1;
	localparam int B_T0_EN = 2;
	localparam int B_T1_EN = 3;
	localparam int B_USB_F = 4;
	localparam int B_T0_F = 5;
	localparam int B_T1_F = 6;
	localparam int B_SER_EN = 0;
	localparam int B_EXT_EN = 1;
	localparam int B_SER_F = 4;
	localparam int B_EXT_F = 5;
	localparam int B_SUSPEND = 0;
	localparam int B_RESUME = 3;
	localparam int B_TMR_RUN = 4;
	localparam int B_STK_FULL = 4;

	// ----------------------------------------------------------------
	// Sources in priority order and their vectors
	// ----------------------------------------------------------------
	localparam int SRC_USB = 0;
	localparam int SRC_T0 = 1;
	localparam int SRC_T1 = 2;
	localparam int SRC_SER = 3;
	localparam int SRC_EXT = 4;
	localparam logic [NSRC-1:0][PC_W-1:0] VECTORS = {
		13'h0014, 13'h0010, 13'h000c, 13'h0008, 13'h0004};

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NEP-1:0] ep_access;
		logic suspend;
		logic resume;
		logic bus_reset;
	} mviu_usb_ev_t;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic phase_two_pulse;
		logic reti;
	} mviu_core_req_t;

	typedef struct packed {
		logic load;
		logic entry;
		logic [PC_W-1:0] target;
	} mviu_core_resp_t;

endpackage : mviu_pkg

// ===== rtl/mviu_stack.sv
// Purpose: Hardware return-address stack of the vectored interrupt unit.
// Assumes: Push is never requested while full, pop never while empty.
// Notes: Top entry is presented combinationally on top.
`timescale 1ns/1ps
module mviu_stack (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Requests
	input wire logic push,
	input wire logic pop,
	input wire logic [mviu_pkg::PC_W-1:0] din,
	// State
	output logic [mviu_pkg::PC_W-1:0] top,
	output logic [mviu_pkg::SP_W-1:0] depth,
	output logic full
);

	typedef struct packed {
		logic [mviu_pkg::STACK_DEPTH-1:0][mviu_pkg::PC_W-1:0] mem;
		logic [mviu_pkg::SP_W-1:0] sp;
	} mviu_stack_state_t;

	mviu_stack_state_t st;
	mviu_stack_state_t next_st;

	localparam logic [mviu_pkg::SP_W-1:0] SP_FULL =
		mviu_pkg::SP_W'(mviu_pkg::STACK_DEPTH);
	localparam logic [mviu_pkg::SP_W-1:0] SP_ONE = 4'h1;

	always_comb begin
		next_st = st;
		if (push && st.sp != SP_FULL) begin
			next_st.mem[st.sp[2:0]] = din;
			next_st.sp = st.sp + SP_ONE;
		end else if (pop && st.sp != '0) begin
			next_st.sp = st.sp - SP_ONE;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign top = st.mem[3'(st.sp - SP_ONE)];
	assign depth = st.sp;
	assign full = (st.sp == SP_FULL);

endmodule : mviu_stack

// ===== rtl/mviu_core.sv
// Purpose: Vectored interrupt unit: flags, enables, priority, stack, APB.
// Assumes: Core signals share MCLK; the external pin is asynchronous.
// Notes: Acceptance happens only on a phase-two pulse from the core.
`timescale 1ns/1ps
module mviu_core (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Request sources
	input wire mviu_pkg::mviu_usb_ev_t USB_EVENTS,
	input wire logic TIMER_ZERO_OVERFLOW,
	input wire logic TIMER_ONE_OVERFLOW,
	input wire logic SERIAL_BYTE_DONE,
	input wire logic SERIAL_ADDR_MATCH,
	input wire logic EXT_IRQ_PIN,
	// Processor core
	input wire mviu_pkg::mviu_core_req_t CORE_REQ,
	output mviu_pkg::mviu_core_resp_t CORE_RESP,
	// Timer control
	output logic [1:0] TIMER_RUN
);

	typedef struct packed {
		logic global_irq_enable;
		logic [mviu_pkg::NSRC-1:0] en;
		logic [mviu_pkg::NSRC-1:0] flag;
		logic [mviu_pkg::NEP-1:0] endpoint_access_request_bits;
		logic [7:0] bus_port_control_status;
		logic [1:0][7:0] tmr_ctrl;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		mviu_pkg::mviu_core_resp_t resp;
	} mviu_state_t;

	mviu_state_t st;
	mviu_state_t next_st;

	logic push;
	logic pop;
	logic take;
	logic [2:0] sel;
	logic [mviu_pkg::PC_W-1:0] stack_top;
	logic [mviu_pkg::SP_W-1:0] stack_depth;
	logic stack_full;
	logic [mviu_pkg::NSRC-1:0] ev_set;
	logic [mviu_pkg::NSRC-1:0] ready_src;
	logic wr;
	logic [31:0] rd_mux;
	logic mapped;

	// ----------------------------------------------------------------
	// Return-address stack
	// ----------------------------------------------------------------
	mviu_stack u_stack (
		.MCLK(MCLK),
		.RESET(RESET),
		.push(push),
		.pop(pop),
		.din(CORE_REQ.pc),
		.top(stack_top),
		.depth(stack_depth),
		.full(stack_full)
	);

	// ----------------------------------------------------------------
	// Source events and arbitration
	// ----------------------------------------------------------------
	always_comb begin
		ev_set = '0;
		ev_set[mviu_pkg::SRC_USB] = |USB_EVENTS.ep_access |
			USB_EVENTS.suspend | USB_EVENTS.resume |
			USB_EVENTS.bus_reset;
		ev_set[mviu_pkg::SRC_T0] = TIMER_ZERO_OVERFLOW;
		ev_set[mviu_pkg::SRC_T1] = TIMER_ONE_OVERFLOW;
		ev_set[mviu_pkg::SRC_SER] = SERIAL_BYTE_DONE |
			SERIAL_ADDR_MATCH;
		ev_set[mviu_pkg::SRC_EXT] = st.ext_s3 & ~st.ext_s2;
		// The global enable gates every source's own enable.
		ready_src = st.en & st.flag &
			{mviu_pkg::NSRC{st.global_irq_enable}};
		sel = 3'h0;
		for (int i = mviu_pkg::NSRC - 1; i >= 0; i--) begin
			if (ready_src[i]) begin
				sel = 3'(i);
			end
		end
		take = CORE_REQ.phase_two_pulse & ~CORE_REQ.reti &
			(|ready_src) & ~stack_full;
		push = take;
		pop = CORE_REQ.reti;
	end

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = '0;
		mapped = 1'b1;
		case (PADDR)
			mviu_pkg::OFS_CTRL0: begin
				rd_mux[mviu_pkg::B_GIE] = st.global_irq_enable;
				rd_mux[mviu_pkg::B_USB_EN] = st.en[mviu_pkg::SRC_USB];
				rd_mux[mviu_pkg::B_T0_EN] = st.en[mviu_pkg::SRC_T0];
				rd_mux[mviu_pkg::B_T1_EN] = st.en[mviu_pkg::SRC_T1];
				rd_mux[mviu_pkg::B_USB_F] = st.flag[mviu_pkg::SRC_USB];
				rd_mux[mviu_pkg::B_T0_F] = st.flag[mviu_pkg::SRC_T0];
				rd_mux[mviu_pkg::B_T1_F] = st.flag[mviu_pkg::SRC_T1];
			end
			mviu_pkg::OFS_CTRL1: begin
				rd_mux[mviu_pkg::B_SER_EN] = st.en[mviu_pkg::SRC_SER];
				rd_mux[mviu_pkg::B_EXT_EN] = st.en[mviu_pkg::SRC_EXT];
				rd_mux[mviu_pkg::B_SER_F] = st.flag[mviu_pkg::SRC_SER];
				rd_mux[mviu_pkg::B_EXT_F] = st.flag[mviu_pkg::SRC_EXT];
			end
			mviu_pkg::OFS_EP_REQ: begin
				rd_mux[mviu_pkg::NEP-1:0] = st.endpoint_access_request_bits;
			end
			mviu_pkg::OFS_BUS_CS: begin
				rd_mux[7:0] = st.bus_port_control_status;
			end
			mviu_pkg::OFS_TMR0_CTRL: begin
				rd_mux[7:0] = st.tmr_ctrl[0];
			end
			mviu_pkg::OFS_TMR1_CTRL: begin
				rd_mux[7:0] = st.tmr_ctrl[1];
			end
			mviu_pkg::OFS_STACK: begin
				rd_mux[mviu_pkg::SP_W-1:0] = stack_depth;
				rd_mux[mviu_pkg::B_STK_FULL] = stack_full;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		wr = PSEL & PENABLE & PWRITE & st.pready;
		// APB answers in the first access cycle.
		next_st.pready = PSEL & ~PENABLE;
		next_st.pslverr = PSEL & ~PENABLE & ~mapped;
		next_st.prdata = (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : '0;
		next_st.ext_s1 = EXT_IRQ_PIN;
		next_st.ext_s2 = st.ext_s1;
		next_st.ext_s3 = st.ext_s2;
		next_st.resp.load = 1'b0;
		next_st.resp.entry = 1'b0;
		// Software writes come first so that hardware sets win.
		if (wr) begin
			case (PADDR)
				mviu_pkg::OFS_CTRL0: begin
					next_st.global_irq_enable =
						PWDATA[mviu_pkg::B_GIE];
					next_st.en[mviu_pkg::SRC_USB] = PWDATA[mviu_pkg::B_USB_EN];
					next_st.en[mviu_pkg::SRC_T0] = PWDATA[mviu_pkg::B_T0_EN];
					next_st.en[mviu_pkg::SRC_T1] = PWDATA[mviu_pkg::B_T1_EN];
					next_st.flag[mviu_pkg::SRC_USB] = PWDATA[mviu_pkg::B_USB_F];
					next_st.flag[mviu_pkg::SRC_T0] = PWDATA[mviu_pkg::B_T0_F];
					next_st.flag[mviu_pkg::SRC_T1] = PWDATA[mviu_pkg::B_T1_F];
				end
				mviu_pkg::OFS_CTRL1: begin
					next_st.en[mviu_pkg::SRC_SER] = PWDATA[mviu_pkg::B_SER_EN];
					next_st.en[mviu_pkg::SRC_EXT] = PWDATA[mviu_pkg::B_EXT_EN];
					next_st.flag[mviu_pkg::SRC_SER] = PWDATA[mviu_pkg::B_SER_F];
					next_st.flag[mviu_pkg::SRC_EXT] = PWDATA[mviu_pkg::B_EXT_F];
				end
				mviu_pkg::OFS_EP_REQ: begin
					// Writing zero clears a bit; ones leave it alone.
					next_st.endpoint_access_request_bits =
						st.endpoint_access_request_bits &
						PWDATA[mviu_pkg::NEP-1:0];
				end
				mviu_pkg::OFS_BUS_CS: begin
					next_st.bus_port_control_status =
						st.bus_port_control_status & PWDATA[7:0];
				end
				mviu_pkg::OFS_TMR0_CTRL: begin
					next_st.tmr_ctrl[0] = PWDATA[7:0];
				end
				mviu_pkg::OFS_TMR1_CTRL: begin
					next_st.tmr_ctrl[1] = PWDATA[7:0];
				end
				default: begin
					next_st.tmr_ctrl = st.tmr_ctrl;
				end
			endcase
		end
		if (pop) begin
			next_st.resp.load = 1'b1;
			next_st.resp.target = stack_top;
		end else if (take) begin
			next_st.global_irq_enable = 1'b0;
			next_st.flag[sel] = 1'b0;
			next_st.resp.load = 1'b1;
			next_st.resp.entry = 1'b1;
			next_st.resp.target = mviu_pkg::VECTORS[sel];
		end
		// Events set flags last; a flag holds until serviced or cleared.
		next_st.flag = next_st.flag | ev_set;
		next_st.endpoint_access_request_bits =
			next_st.endpoint_access_request_bits |
			USB_EVENTS.ep_access;
		next_st.bus_port_control_status[mviu_pkg::B_SUSPEND] =
			next_st.bus_port_control_status[mviu_pkg::B_SUSPEND] |
			USB_EVENTS.suspend;
		next_st.bus_port_control_status[mviu_pkg::B_RESUME] =
			next_st.bus_port_control_status[mviu_pkg::B_RESUME] |
			USB_EVENTS.resume;
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA = st.prdata;
	assign PREADY = st.pready;
	assign PSLVERR = st.pslverr;
	assign CORE_RESP = st.resp;
	assign TIMER_RUN = {st.tmr_ctrl[1][mviu_pkg::B_TMR_RUN],
		st.tmr_ctrl[0][mviu_pkg::B_TMR_RUN]};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	sequence take_seq;
		CORE_REQ.phase_two_pulse && !CORE_REQ.reti &&
			(|(st.en & st.flag)) && st.global_irq_enable && !stack_full;
	endsequence

	sequence entry_seq;
		CORE_RESP.load && CORE_RESP.entry && !st.global_irq_enable;
	endsequence

	AST_ENTRY_LOADS_VECTOR: assert property (
		take_seq |=> entry_seq ##0
			(stack_depth == $past(stack_depth) + 4'h1))
		else $error("Accepted request did not push and vector.");

	AST_FULL_BLOCKS: assert property (
		stack_full && !CORE_REQ.reti |=> !CORE_RESP.entry)
		else $error("Interrupt entered with a full stack.");

	AST_ONLY_ON_PULSE: assert property (
		!CORE_REQ.phase_two_pulse |=> !CORE_RESP.entry)
		else $error("Interrupt entered without a phase-two pulse.");

	AST_GIE_MASKS: assert property (
		!st.global_irq_enable |=> !CORE_RESP.entry)
		else $error("Interrupt entered with global enable low.");

	AST_USB_FIRST: assert property (
		take_seq ##0 (st.en[0] && st.flag[0] && !ev_set[0]) |=>
			CORE_RESP.target == 13'h0004 && !st.flag[0])
		else $error("Highest priority source was not chosen.");

	AST_RETI_RESUMES: assert property (
		CORE_REQ.reti && stack_depth != 4'h0 |=>
			CORE_RESP.load && CORE_RESP.target == $past(stack_top) &&
			stack_depth == $past(stack_depth) - 4'h1)
		else $error("Return did not resume from the stack.");

	AST_FLAG_HOLDS: assert property (
		st.flag[2] && !wr && !(take && sel == 3'h2) |=> st.flag[2])
		else $error("Timer one flag dropped on its own.");

	AST_EXT_EDGE: assert property (
		(st.ext_s2 && !st.ext_s1) ##1 (st.ext_s3 && !st.ext_s2) |=>
			st.flag[4] || CORE_RESP.entry)
		else $error("External falling edge did not set its flag.");

	AST_TIMER_RUN: assert property (
		wr && PADDR == 8'h10 |=> TIMER_RUN[0] == $past(PWDATA[4]))
		else $error("Timer zero run bit did not follow the write.");

	AST_SUSPEND_BIT: assert property (
		USB_EVENTS.suspend |=>
			st.bus_port_control_status[0] &&
			(st.flag[0] || CORE_RESP.entry))
		else $error("Suspend did not set status bit and flag.");

	AST_TIMER_FLAG_CLEARED: assert property (
		take && sel == 3'h1 && !ev_set[1] |=>
			!st.flag[1] && !st.global_irq_enable)
		else $error("Serviced timer zero flag was not cleared.");

	AST_EP_BITS_HOLD: assert property (
		!(wr && PADDR == mviu_pkg::OFS_EP_REQ) |=>
			&(st.endpoint_access_request_bits |
			~$past(st.endpoint_access_request_bits)))
		else $error("Endpoint request bit dropped without a write.");

	AST_SERIAL_FLAG: assert property (
		SERIAL_BYTE_DONE || SERIAL_ADDR_MATCH |=> st.flag[3])
		else $error("Serial event did not set its flag.");

endmodule : mviu_core

// ===== verif/mviu_core_model.sv
// Purpose: Behavioural processor core facing the interrupt unit.
// Assumes: One phase-two pulse per frame of 4 or 11 cycles.
// Notes: A requested return issues once, in the cycle before a pulse.
`timescale 1ns/1ps
module mviu_core_model (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Bench control
	input wire logic slow,
	input wire logic ret_req,
	// Interrupt unit
	input wire mviu_pkg::mviu_core_resp_t resp,
	output mviu_pkg::mviu_core_req_t req
);
	logic [3:0] cnt;
	logic [mviu_pkg::PC_W-1:0] pc;
	logic pending;
	logic pulse;

	assign pulse = (cnt == 4'h0);
	assign req.pc = pc;
	assign req.phase_two_pulse = pulse;
	assign req.reti = pending & (cnt == 4'h1);

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			cnt <= 4'h0;
			pc <= 13'h0100;
			pending <= 1'b0;
		end else begin
			cnt <= pulse ? (slow ? 4'ha : 4'h3) : cnt - 4'h1;
			if (resp.load) begin
				pc <= resp.target;
			end else if (pulse) begin
				pc <= pc + 13'h1;
			end
			if (ret_req) begin
				pending <= 1'b1;
			end else if (cnt == 4'h1) begin
				pending <= 1'b0;
			end
		end
	end
endmodule : mviu_core_model

// ===== verif/tb_mcu_vectored_interrupt_unit.sv
// Purpose: Self-checking bench for the vectored interrupt unit.
// Assumes: Zero-wait APB slave and the core model beside it.
// Notes: Pushed return addresses are mirrored in a queue.
`timescale 1ns/1ps
module tb_mcu_vectored_interrupt_unit;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic last_err;
	mviu_pkg::mviu_usb_ev_t usb_ev = '0;
	logic [3:0] src = 4'h0;
	logic ext_pin = 1'b1;
	logic slow = 1'b0;
	logic ret_req = 1'b0;
	mviu_pkg::mviu_core_req_t core_req;
	mviu_pkg::mviu_core_resp_t core_resp;
	logic [1:0] timer_run;
	logic prev_pulse = 1'b0;
	logic [12:0] pulse_pc = 13'h0;
	logic [12:0] saved[$];
	int cycles = 0;
	int fail_count = 0;
	int samples_checked = 0;

	mviu_core i_mviu_core (.MCLK(mclk), .RESET(reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.USB_EVENTS(usb_ev), .TIMER_ZERO_OVERFLOW(src[3]),
		.TIMER_ONE_OVERFLOW(src[2]), .SERIAL_BYTE_DONE(src[1]),
		.SERIAL_ADDR_MATCH(src[0]), .EXT_IRQ_PIN(ext_pin),
		.CORE_REQ(core_req), .CORE_RESP(core_resp), .TIMER_RUN(timer_run));
	mviu_core_model i_mviu_core_model (.MCLK(mclk), .RESET(reset),
		.slow(slow), .ret_req(ret_req), .resp(core_resp), .req(core_req));

	always #10 mclk = ~mclk;

	always @(posedge mclk) begin
		prev_pulse <= core_req.phase_two_pulse;
		if (core_req.phase_two_pulse) begin
			pulse_pc <= core_req.pc;
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rchk

	task automatic fire(input logic [6:0] u, input logic [3:0] s);
		usb_ev <= u;
		src <= s;
		@(posedge mclk);
		usb_ev <= '0;
		src <= 4'h0;
		@(posedge mclk);
	endtask : fire

	task automatic wait_load(output logic got);
		int n;
		n = 0;
		@(posedge mclk);
		while (core_resp.load !== 1'b1 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		got = (core_resp.load === 1'b1);
	endtask : wait_load

	task automatic expect_entry(input logic [12:0] vec);
		logic got;
		wait_load(got);
		check(32'(core_resp.entry), 32'h1);
		check(32'(core_resp.target), 32'(vec));
		check(32'(prev_pulse), 32'h1);
		saved.push_back(pulse_pc);
	endtask : expect_entry

	task automatic do_ret();
		logic got;
		ret_req <= 1'b1;
		@(posedge mclk);
		ret_req <= 1'b0;
		wait_load(got);
		check(32'(core_resp.entry), 32'h0);
		check(32'(core_resp.target), 32'(saved.pop_back()));
	endtask : do_ret

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_reset();
		for (int a = 0; a < 8; a++) begin
			rchk(8'(a * 4), 32'h0);
		end
		check(32'(last_err), 32'h1);
	endtask : s_reset

	task automatic s_usb();
		logic [6:0] ev [4] = '{7'h20, 7'h04, 7'h02, 7'h01};
		for (int i = 0; i < 4; i++) begin
			fire(ev[i], 4'h0);
			rchk(mviu_pkg::OFS_CTRL0, 32'h10);
			wr(mviu_pkg::OFS_CTRL0, 32'h0);
		end
		rchk(mviu_pkg::OFS_EP_REQ, 32'h4);
		rchk(mviu_pkg::OFS_BUS_CS, 32'h9);
		wr(mviu_pkg::OFS_EP_REQ, 32'h0);
		wr(mviu_pkg::OFS_BUS_CS, 32'h0);
		rchk(mviu_pkg::OFS_EP_REQ, 32'h0);
		fire(7'h0, 4'h2);
		rchk(mviu_pkg::OFS_CTRL1, 32'h10);
		wr(mviu_pkg::OFS_CTRL1, 32'h0);
	endtask : s_usb

	task automatic s_run();
		wr(mviu_pkg::OFS_TMR0_CTRL, 32'h10);
		check(32'(timer_run), 32'h1);
		wr(mviu_pkg::OFS_TMR1_CTRL, 32'h10);
		wr(mviu_pkg::OFS_TMR0_CTRL, 32'h0);
		check(32'(timer_run), 32'h2);
		wr(mviu_pkg::OFS_TMR1_CTRL, 32'h0);
	endtask : s_run

	task automatic s_entry();
		logic got;
		slow <= 1'b1;
		wr(mviu_pkg::OFS_CTRL0, 32'h05);
		fire(7'h0, 4'h8);
		expect_entry(13'h008);
		rchk(mviu_pkg::OFS_CTRL0, 32'h04);
		rchk(mviu_pkg::OFS_STACK, 32'h01);
		do_ret();
		wr(mviu_pkg::OFS_CTRL0, 32'h01);
		fire(7'h0, 4'h8);
		wait_load(got);
		check(32'(got), 32'h0);
		rchk(mviu_pkg::OFS_CTRL0, 32'h21);
		wr(mviu_pkg::OFS_CTRL0, 32'h0);
	endtask : s_entry

	task automatic s_prio();
		logic [31:0] q;
		logic [12:0] vec [5] = '{13'h004, 13'h008, 13'h00c, 13'h010, 13'h014};
		wr(mviu_pkg::OFS_CTRL0, 32'h0e);
		wr(mviu_pkg::OFS_CTRL1, 32'h03);
		ext_pin <= 1'b0;
		fire(7'h04, 4'hd);
		rchk(mviu_pkg::OFS_CTRL0, 32'h7e);
		rchk(mviu_pkg::OFS_CTRL1, 32'h33);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, mviu_pkg::OFS_CTRL0, 32'h0, q);
			wr(mviu_pkg::OFS_CTRL0, q | 32'h1);
			expect_entry(vec[i]);
		end
		rchk(mviu_pkg::OFS_STACK, 32'h05);
		repeat (5) do_ret();
		rchk(mviu_pkg::OFS_CTRL0, 32'h0e);
		rchk(mviu_pkg::OFS_CTRL1, 32'h03);
		ext_pin <= 1'b1;
		wr(mviu_pkg::OFS_CTRL0, 32'h0);
		wr(mviu_pkg::OFS_CTRL1, 32'h0);
	endtask : s_prio

	task automatic s_full();
		logic got;
		slow <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			wr(mviu_pkg::OFS_CTRL0, 32'h49);
			expect_entry(13'h00c);
		end
		rchk(mviu_pkg::OFS_STACK, 32'h18);
		wr(mviu_pkg::OFS_CTRL0, 32'h49);
		wait_load(got);
		check(32'(got), 32'h0);
		rchk(mviu_pkg::OFS_CTRL0, 32'h49);
		do_ret();
		expect_entry(13'h00c);
		repeat (8) do_ret();
		rchk(mviu_pkg::OFS_STACK, 32'h00);
	endtask : s_full

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		s_reset();
		s_usb();
		s_run();
		s_entry();
		s_prio();
		s_full();
		conclude();
	end
endmodule : tb_mcu_vectored_interrupt_unit
